/* core/cache_line_command_unit.sv */
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cache_line_command_unit
  import line_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Write-back request
  output logic wbReq,
  output logic [31:0] wbAddr,
  // Global enable level
  output logic cacheEnable
);

  tag_entry_t tagMem [2][1 << SET_W];
  logic [31:0] dataMem [2][1 << (SET_W + WORD_W)];

  state_t state_r, state_nxt;
  logic go_r, go_nxt;
  logic enable_r, enable_nxt;
  cmd_t cmd_r, cmd_nxt;
  logic waySel_r, waySel_nxt;
  logic tag_data_select_r, tag_data_select_nxt;
  logic [11:0] setWord_r, setWord_nxt;
  logic [29:0] physAddr_r, physAddr_nxt;
  result_t result_r, result_nxt;
  logic [31:0] value_r, value_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wbReq_r, wbReq_nxt;
  logic [31:0] wbAddr_r, wbAddr_nxt;

  logic tagWe, dataWe;
  logic tagWay, dataWay;
  logic [SET_W-1:0] tagIdx;
  logic [SET_W+WORD_W-1:0] dataIdx;
  tag_entry_t tagWr;
  logic [31:0] dataWr;

  logic apbWr, apbRd, mapped;
  logic [31:0] ctrlWord, srchWord, rdWord;
  logic [SET_W-1:0] curSet;
  logic [WORD_W-1:0] curWord;
  tag_entry_t ent0, ent1, ent;
  logic hit0, hit1, curWay, lineValid;
  logic [31:0] curData;

  assign apbWr = psel && penable && pready_r && pwrite;
  assign apbRd = psel && penable && !pready_r && !pwrite;
  assign mapped = (paddr == OFF_MAIN) || (paddr == OFF_CTRL)
    || (paddr == OFF_SRCH) || (paddr == OFF_VAL);

  // Readback images; bit 23 of the control image is held at zero
  assign ctrlWord = {4'h0, cmd_r, 1'b0, result_r, 2'h0, tag_data_select_r, waySel_r,
    2'h0, setWord_r, 1'b0, go_r};
  assign srchWord = {physAddr_r[29:0], 1'b0, go_r};

  always_comb
  begin
    unique case (paddr)
      OFF_MAIN: rdWord = {31'h0, enable_r};
      OFF_CTRL: rdWord = ctrlWord;
      OFF_SRCH: rdWord = srchWord;
      OFF_VAL: rdWord = value_r;
      default: rdWord = RST_WORD;
    endcase
  end

  // Target line selection and lookup
  always_comb
  begin
    if (cmd_r.addrSel)
    begin
      curSet = physAddr_r[11:2];
      curWord = physAddr_r[1:0];
    end
    else
    begin
      curSet = setWord_r[11:2];
      curWord = setWord_r[1:0];
    end
    ent0 = tagMem[0][curSet];
    ent1 = tagMem[1][curSet];
    hit0 = ent0.valid && (ent0.tag == physAddr_r[29:12]);
    hit1 = ent1.valid && (ent1.tag == physAddr_r[29:12]);
    if (cmd_r.addrSel)
    begin
      curWay = !hit0 && hit1;
    end
    else
    begin
      curWay = waySel_r;
    end
    ent = curWay ? ent1 : ent0;
    if (cmd_r.addrSel && !hit0 && !hit1)
    begin
      ent.valid = 1'b0;
      ent.modified = 1'b0;
    end
    lineValid = ent.valid;
    curData = dataMem[curWay][{curSet, curWord}];
  end

  always_comb
  begin
    state_nxt = state_r;
    go_nxt = go_r;
    enable_nxt = enable_r;
    cmd_nxt = cmd_r;
    waySel_nxt = waySel_r;
    tag_data_select_nxt = tag_data_select_r;
    setWord_nxt = setWord_r;
    physAddr_nxt = physAddr_r;
    result_nxt = result_r;
    value_nxt = value_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    wbReq_nxt = 1'b0;
    wbAddr_nxt = wbAddr_r;
    tagWe = 1'b0;
    dataWe = 1'b0;
    tagWay = curWay;
    dataWay = curWay;
    tagIdx = curSet;
    dataIdx = {curSet, curWord};
    tagWr = ent;
    dataWr = value_r;

    // APB answer one cycle into the access phase
    if (psel && penable && !pready_r)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = !mapped;
      if (apbRd)
      begin
        prdata_nxt = rdWord;
      end
    end

    // Software writes; all fields except the enable bit frozen while busy
    if (apbWr && paddr == OFF_MAIN)
    begin
      enable_nxt = pwdata[POS_ENABLE];
    end
    if (apbWr && !go_r)
    begin
      unique case (paddr)
        OFF_CTRL:
        begin
          cmd_nxt = cmd_t'(pwdata[POS_CMD_LO +: 4]);
          waySel_nxt = pwdata[POS_WAY];
          tag_data_select_nxt = pwdata[POS_TAG_DATA_SELECT];
          setWord_nxt = pwdata[13:2];
          go_nxt = pwdata[POS_GO];
        end
        OFF_SRCH:
        begin
          physAddr_nxt = pwdata[31:2];
          go_nxt = pwdata[POS_GO];
        end
        OFF_VAL: value_nxt = pwdata;
        default: ;
      endcase
    end

    unique case (state_r)
      ST_IDLE:
      begin
        if (go_r)
        begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN:
      begin
        // Enable bit deliberately not consulted
        state_nxt = ST_IDLE;
        go_nxt = 1'b0;
        if (cmd_r.access)
        begin
          if (!cmd_r.addrSel && cmd_r.op == OP_SEARCH)
          begin
            if (tag_data_select_r)
            begin
              tagWe = 1'b1;
              tagWr = {value_r[31:POS_TAG_LO], value_r[1], value_r[0]};
            end
            else
            begin
              dataWe = 1'b1;
            end
          end
        end
        else
        begin
          result_nxt = {curWay, ent.modified, ent.valid};
          value_nxt = tag_data_select_r ? {ent.tag, 12'h0, ent.modified, ent.valid}
            : curData;
          if (lineValid)
          begin
            unique case (cmd_r.op)
              OP_SEARCH: ;
              OP_INVAL:
              begin
                tagWe = 1'b1;
                tagWr.valid = 1'b0;
                tagWr.modified = 1'b0;
              end
              OP_PUSH, OP_CLEAR:
              begin
                tagWe = 1'b1;
                tagWr.modified = 1'b0;
                tagWr.valid = (cmd_r.op == OP_PUSH);
                wbReq_nxt = ent.modified;
                if (ent.modified)
                begin
                  wbAddr_nxt = {ent.tag, curSet, 4'h0};
                end
              end
            endcase
          end
        end
      end
    endcase
  end

  // Arrays are not cleared at reset
  always_ff @(posedge clk)
  begin
    if (tagWe)
    begin
      tagMem[tagWay][tagIdx] <= tagWr;
    end
    if (dataWe)
    begin
      dataMem[dataWay][dataIdx] <= dataWr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      go_r <= 1'b0;
      enable_r <= 1'b0;
      cmd_r <= cmd_t'(4'h0);
      waySel_r <= 1'b0;
      tag_data_select_r <= 1'b0;
      setWord_r <= 12'h000;
      physAddr_r <= 30'h0;
      result_r <= result_t'(3'h0);
      value_r <= RST_WORD;
      prdata_r <= RST_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      wbReq_r <= 1'b0;
      wbAddr_r <= RST_WORD;
    end
    else
    begin
      state_r <= state_nxt;
      go_r <= go_nxt;
      enable_r <= enable_nxt;
      cmd_r <= cmd_nxt;
      waySel_r <= waySel_nxt;
      tag_data_select_r <= tag_data_select_nxt;
      setWord_r <= setWord_nxt;
      physAddr_r <= physAddr_nxt;
      result_r <= result_nxt;
      value_r <= value_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      wbReq_r <= wbReq_nxt;
      wbAddr_r <= wbAddr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign wbReq = wbReq_r;
  assign wbAddr = wbAddr_r;
  assign cacheEnable = enable_r;

endmodule : cache_line_command_unit
`default_nettype wire

/* core/line_cmd_pkg.sv */
package line_cmd_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_MAIN = 12'h000;
  localparam logic [11:0] OFF_CTRL = 12'h004;
  localparam logic [11:0] OFF_SRCH = 12'h008;
  localparam logic [11:0] OFF_VAL = 12'h00c;

  // Field positions
  localparam int POS_GO = 0;
  localparam int POS_ENABLE = 0;
  localparam int POS_WAY = 16;
  localparam int POS_TAG_DATA_SELECT = 17;
  localparam int POS_RES_LO = 20;
  localparam int POS_CMD_LO = 24;
  localparam int POS_TAG_LO = 14;

  // Array geometry
  localparam int SET_W = 10;
  localparam int WORD_W = 2;
  localparam int TAG_W = 18;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic {WAY0, WAY1} way_t;

  typedef struct packed {
    logic access;
    logic addrSel;
    logic [1:0] op;
  } cmd_t;

  typedef struct packed {
    logic way;
    logic modified;
    logic valid;
  } result_t;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic modified;
    logic valid;
  } tag_entry_t;

  localparam logic [1:0] OP_SEARCH = 2'h0;
  localparam logic [1:0] OP_INVAL = 2'h1;
  localparam logic [1:0] OP_PUSH = 2'h2;
  localparam logic [1:0] OP_CLEAR = 2'h3;

  typedef enum logic {ST_IDLE, ST_RUN} state_t;

endpackage : line_cmd_pkg

/* sim/cache_line_command_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cache_line_command_unit_tb;
  import line_cmd_pkg::*;
  localparam logic [17:0] TAG = 18'h2a5b3;
  localparam logic [31:0] PA = {TAG, 10'h005, 4'h0};
  localparam logic [31:0] TW = {TAG, 12'h000, 2'b11};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, wbAddr, rd, lastWb;
  logic pready, pslverr, wbReq, cacheEnable, lastErr;
  int errors = 0;
  int comparisons = 0;
  int wbCnt = 0;
  int cyc = 0;
  cache_line_command_unit u_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wbReq(wbReq), .wbAddr(wbAddr), .cacheEnable(cacheEnable));
  initial forever #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (wbReq === 1'b1)
    begin
      wbCnt = wbCnt + 1;
      lastWb = wbAddr;
    end
    if (cyc == 3000)
    begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Control word with go set
  function automatic logic [31:0] cw(input logic [3:0] c, input int t, input int w,
    input logic [13:0] a);
    return {4'h0, c, 6'h00, 1'(t), 1'(w), 2'h0, a[13:2], 2'h1};
  endfunction : cw
  // Start a command and poll until go clears
  task cmd(input logic [11:0] a, input logic [31:0] w);
    int n;
    n = 0;
    apb(1'b1, a, w);
    do apb(1'b0, OFF_CTRL, 32'h0); while (rd[0] !== 1'b0 && n++ < 8);
    chk(rd[0], 32'h0);
  endtask : cmd
  task s_reset();
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, RST_WORD);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, lastErr}, 32'h1);
  endtask : s_reset
  task s_write();
    apb(1'b1, OFF_VAL, TW);
    cmd(OFF_CTRL, cw(4'h8, 1, 1, 14'h0050));
    apb(1'b1, OFF_VAL, {TAG ^ 18'h1, 12'h0, 2'b10});
    cmd(OFF_CTRL, cw(4'h8, 1, 0, 14'h0050));
    apb(1'b1, OFF_VAL, 32'hc0de_0001);
    cmd(OFF_CTRL, cw(4'h8, 0, 1, 14'h0058));
    cmd(OFF_CTRL, cw(4'h0, 1, 1, 14'h0050));
    chk(rd[23:20], 32'h7);
    apb(1'b0, OFF_VAL, 32'h0);
    chk(rd, TW);
    cmd(OFF_CTRL, cw(4'h0, 0, 1, 14'h0058));
    apb(1'b0, OFF_VAL, 32'h0);
    chk(rd, 32'hc0de_0001);
  endtask : s_write
  task s_phys();
    apb(1'b1, OFF_CTRL, cw(4'h4, 1, 0, 14'h0) - 1);
    cmd(OFF_SRCH, PA | 32'h1);
    chk(rd[22:20], 32'h7);
    apb(1'b0, OFF_VAL, 32'h0);
    chk(rd, TW);
    cmd(OFF_SRCH, (PA ^ 32'h8000) | 32'h1);
    chk(rd[22:20], 32'h0);
  endtask : s_phys
  task s_modes();
    int n0;
    n0 = wbCnt;
    apb(1'b1, OFF_CTRL, cw(4'h6, 1, 0, 14'h0) - 1);
    cmd(OFF_SRCH, PA | 32'h1);
    chk(wbCnt - n0, 32'h1);
    chk(lastWb, PA);
    cmd(OFF_CTRL, cw(4'h0, 1, 1, 14'h0050));
    chk(rd[22:20], 32'h5);
    cmd(OFF_CTRL, cw(4'h2, 1, 0, 14'h0050));
    cmd(OFF_CTRL, cw(4'h0, 1, 0, 14'h0050));
    chk(rd[22:20], 32'h2);
    cmd(OFF_CTRL, cw(4'h3, 1, 1, 14'h0050));
    cmd(OFF_CTRL, cw(4'h0, 1, 1, 14'h0050));
    chk(rd[22:20], 32'h4);
    apb(1'b1, OFF_VAL, TW);
    cmd(OFF_CTRL, cw(4'h8, 1, 1, 14'h0050));
    cmd(OFF_CTRL, cw(4'h1, 1, 1, 14'h0050));
    chk(wbCnt - n0, 32'h1);
    for (int c = 9; c < 16; c++)
    begin
      cmd(OFF_CTRL, cw(4'(c), 1, 1, 14'h0050));
      chk(rd[22:20], 32'h7);
    end
    apb(1'b1, OFF_VAL, TW);
    cmd(OFF_CTRL, cw(4'h8, 1, 1, 14'h0050));
    apb(1'b1, OFF_CTRL, cw(4'h7, 1, 0, 14'h0) - 1);
    cmd(OFF_SRCH, PA | 32'h1);
    chk(wbCnt - n0, 32'h2);
    chk(lastWb, PA);
    apb(1'b1, OFF_CTRL, cw(4'h5, 1, 0, 14'h0) - 1);
    cmd(OFF_SRCH, PA | 32'h1);
    chk(rd[22:20], 32'h0);
    apb(1'b1, OFF_MAIN, 32'h1);
    @(posedge clk);
    chk({31'h0, cacheEnable}, 32'h1);
    apb(1'b0, OFF_MAIN, 32'h0);
    chk(rd, 32'h1);
    cmd(OFF_CTRL, cw(4'h0, 1, 1, 14'h0050));
    chk(rd[22:20], 32'h4);
  endtask : s_modes
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    s_reset();
    s_write();
    s_phys();
    s_modes();
    report_and_stop();
  end
endmodule : cache_line_command_unit_tb
`default_nettype wire

/* sim/line_cmd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module line_cmd_checker
  import line_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic wbReq,
  input wire logic [31:0] wbAddr,
  input wire logic cacheEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic acc = psel && penable && pready;
  wire logic mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
  wire logic goWr = acc && pwrite && pwdata[0] && (paddr == OFF_CTRL || paddr == OFF_SRCH);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong");
  chk_rsvd_zero: assert property (acc && !pwrite && paddr == OFF_CTRL |-> !prdata[23])
    else $error("bit 23 set");
  chk_wb_cause: assert property (wbReq |-> $past(goWr, 3))
    else $error("write-back without command");
  chk_wb_pulse: assert property (wbReq |=> !wbReq)
    else $error("write-back long");
  chk_wb_align: assert property (wbReq |-> wbAddr[3:0] == 4'h0)
    else $error("write-back unaligned");
  chk_enable_wr: assert property (acc && pwrite && paddr == OFF_MAIN |=>
    cacheEnable == $past(pwdata[0]))
    else $error("enable not written");
endmodule : line_cmd_checker
bind cache_line_command_unit line_cmd_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .wbReq(wbReq), .wbAddr(wbAddr),
  .cacheEnable(cacheEnable));
`default_nettype wire
